//--- rtl/bandwidth_floor_portion_config.sv
// bandwidth floor fraction and portion grant map store, four security frames
`timescale 1ns/1ps
`default_nettype none
`include "bw_floor_consts.svh"

module bandwidth_floor_portion_config (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic reg_req_i,
  input wire bw_floor_pkg::space_t reg_space_i,
  input wire logic [`FRAME_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic reg_ack_o,
  output logic [31:0] reg_rdata_o,
  input wire logic [`SPACE_COUNT-1:0][`PARTITION_ID_W-1:0] selected_partition_field_i,
  input wire logic [`SPACE_COUNT-1:0][`INSTANCE_ID_W-1:0] resource_instance_choice_i,
  input wire logic [`SPACE_COUNT-1:0] sel_internal_i,
  input wire logic qry_req_i,
  input wire bw_floor_pkg::space_t qry_space_i,
  input wire bw_floor_pkg::partition_t qry_partition_i,
  input wire bw_floor_pkg::instance_t qry_instance_i,
  input wire bw_floor_pkg::fraction_t qry_use_i,
  input wire bw_floor_pkg::portion_t qry_portion_i,
  output logic qry_ack_o,
  output logic preferred_o,
  output logic portion_permit_o
);
  import bw_floor_pkg::*;

  // ==========================================================================
  // sizing
  localparam int SLOTS = `SPACE_COUNT * `PARTITION_COUNT * `INSTANCE_COUNT;
  localparam int GRANT_ENTRIES = SLOTS * `GRANT_WORDS;
  localparam int GIDX_W = $clog2(GRANT_ENTRIES);

  // ==========================================================================
  // masks
  // implemented fraction bits sit at the top of the 16-bit field
  function automatic fraction_t fraction_mask(int w);
    fraction_t m;
    m = ~(16'hFFFF >> w);
    return m;
  endfunction

  // a grant bit is kept only while its portion number is at most the map width
  function automatic grant_word_t grant_mask(grant_idx_t n);
    grant_word_t m;
    int base;
    m = 32'h0000_0000;
    base = int'(n) * `GRANT_WORD_W;
    for (int x = 0; x < `GRANT_WORD_W; x++) begin
      m[x] = (base + x) <= `PORTION_MAP_WIDTH;
    end
    return m;
  endfunction

  // flat index of one grant word of one slot
  function automatic logic [GIDX_W-1:0] grant_index(slot_t s, grant_idx_t n);
    logic [GIDX_W-1:0] r;
    r = GIDX_W'(int'(s) * `GRANT_WORDS + int'(n));
    return r;
  endfunction

  localparam fraction_t FLOOR_MASK = fraction_mask(`BW_FRACTION_WIDTH);

  // ==========================================================================
  // storage
  fraction_t floor_r [SLOTS];
  grant_word_t grant_r [GRANT_ENTRIES];

  // ==========================================================================
  // selector of the accessing frame
  partition_t acc_part;
  instance_t acc_inst;
  logic acc_internal;
  slot_t acc_slot;

  // each frame sees only the selector instance of its own space
  assign acc_part = selected_partition_field_i[reg_space_i];
  assign acc_inst = `FEAT_INSTANCE_CHOICE ? resource_instance_choice_i[reg_space_i]
                                          : instance_t'(0);
  assign acc_internal = sel_internal_i[reg_space_i];
  assign acc_slot = slot_of(reg_space_i, acc_part, acc_inst);

  // ==========================================================================
  // address decode
  logic frame_ok;
  logic sel_ok;
  logic hit_floor;
  logic hit_grant;
  grant_idx_t grant_n;
  logic floor_live;
  logic grant_live;
  logic [GIDX_W-1:0] grant_at;

  // root and realm frames exist, read-write, only with the realm extension
  assign frame_ok = space_ok(reg_space_i);
  // a selector whose internal flag disagrees with narrowing reaches nothing
  assign sel_ok = target_ok(acc_part, acc_inst) && (acc_internal == `FEAT_NARROWING);
  assign hit_floor = (reg_addr_i == `OFS_FLOOR_FRACTION);
  assign hit_grant = (reg_addr_i[13:9] == `GRANT_MAP_BASE_TOP) && (reg_addr_i[1:0] == 2'h0);
  assign grant_n = grant_idx_t'(reg_addr_i[8:2]);
  assign floor_live = hit_floor && frame_ok && sel_ok
                      && `FEAT_BW_PARTITIONING && `FEAT_FLOOR_CONTROL;
  // words past the map width are not stored and behave as reserved
  assign grant_live = hit_grant && frame_ok && sel_ok && `FEAT_BW_PARTITIONING
                      && `FEAT_PORTION_MAP
                      && (grant_n < grant_idx_t'(`GRANT_WORDS));
  assign grant_at = grant_index(acc_slot, grant_n);

  // ==========================================================================
  // writes
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < SLOTS; i++) begin
        floor_r[i] <= `FLOOR_RESET;
      end
    end else if (reg_req_i && reg_wr_i && floor_live) begin
      floor_r[acc_slot] <= reg_wdata_i[`FRACTION_FIELD_MSB:0] & FLOOR_MASK;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < GRANT_ENTRIES; i++) begin
        grant_r[i] <= `GRANT_RESET;
      end
    end else if (reg_req_i && reg_wr_i && grant_live) begin
      grant_r[grant_at] <= reg_wdata_i & grant_mask(grant_n);
    end
  end

  // ==========================================================================
  // reads, answered one cycle after the request
  logic [31:0] rd_nxt;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (floor_live) begin
      rd_nxt = {16'h0000, floor_r[acc_slot]};
    end else if (grant_live) begin
      rd_nxt = grant_r[grant_at];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      reg_ack_o <= 1'b0;
    end else begin
      reg_ack_o <= reg_req_i;
    end
  end

  // write answers read as zero so a stale value never leaks across frames
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_req_i) begin
      reg_rdata_o <= reg_wr_i ? 32'h0000_0000 : rd_nxt;
    end
  end

  // ==========================================================================
  // regulation-side lookup port
  cfg_lookup_if look ();

  assign look.floor = floor_r[look.slot];
  assign look.grant = (look.word < grant_idx_t'(`GRANT_WORDS))
                      ? grant_r[grant_index(look.slot, look.word)]
                      : 32'h0000_0000;

  bw_floor_query u_query (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .qry_req_i(qry_req_i),
    .qry_space_i(qry_space_i),
    .qry_partition_i(qry_partition_i),
    .qry_instance_i(qry_instance_i),
    .qry_use_i(qry_use_i),
    .qry_portion_i(qry_portion_i),
    .look(look.user),
    .qry_ack_o(qry_ack_o),
    .preferred_o(preferred_o),
    .portion_permit_o(portion_permit_o)
  );
endmodule // bandwidth_floor_portion_config

`default_nettype wire

//--- rtl/bw_floor_consts.svh
// constants for the bandwidth floor and portion grant configuration bank
`ifndef BW_FLOOR_CONSTS_SVH
`define BW_FLOOR_CONSTS_SVH

// ==========================================================================
// frame offsets
`define OFS_FLOOR_FRACTION 14'h0200
`define OFS_GRANT_MAP_BASE 14'h2000
`define GRANT_MAP_BASE_TOP 5'h10
`define GRANT_MAP_MAX_REGS 128
`define FRAME_ADDR_W 14

// ==========================================================================
// field layout
`define FRACTION_FIELD_W 16
`define FRACTION_FIELD_MSB 15
`define GRANT_WORD_W 32
`define PORTION_W 12
`define PORTION_WORD_MSB 11
`define PORTION_WORD_LSB 5
`define PORTION_BIT_MSB 4
`define FLOOR_RESET 16'h0000
`define GRANT_RESET 32'h0000_0000

// ==========================================================================
// implementation sizing and advertised features
`define PARTITION_ID_W 8
`define PARTITION_COUNT 4
`define INSTANCE_ID_W 4
`define INSTANCE_COUNT 2
`define SPACE_COUNT 4
`define SLOT_W 5
`define FEAT_BW_PARTITIONING 1'b1
`define FEAT_FLOOR_CONTROL 1'b1
`define FEAT_PORTION_MAP 1'b1
`define FEAT_INSTANCE_CHOICE 1'b1
`define FEAT_NARROWING 1'b0
`define FEAT_REALM_EXTENSION 1'b1
`define BW_FRACTION_WIDTH 12
`define PORTION_MAP_WIDTH 48
`define GRANT_WORDS 2
`define GRANT_WORD_IDX_W 7

`endif

//--- rtl/bw_floor_pkg.sv
// types and shared decode functions of the bandwidth floor configuration bank
`default_nettype none
`include "bw_floor_consts.svh"

package bw_floor_pkg;

  // ========================================================================
  // types
  typedef enum logic [1:0] {
    SPACE_SECURE = 2'h0,
    SPACE_NONSECURE = 2'h1,
    SPACE_ROOT = 2'h3,
    SPACE_REALM = 2'h2
  } space_t;

  typedef logic [`PARTITION_ID_W-1:0] partition_t;
  typedef logic [`INSTANCE_ID_W-1:0] instance_t;
  typedef logic [`SLOT_W-1:0] slot_t;
  typedef logic [`FRACTION_FIELD_W-1:0] fraction_t;
  typedef logic [`GRANT_WORD_W-1:0] grant_word_t;
  typedef logic [`GRANT_WORD_IDX_W-1:0] grant_idx_t;
  typedef logic [`PORTION_W-1:0] portion_t;

  // ========================================================================
  // functions
  // storage slot of one space, partition and resource instance
  function automatic slot_t slot_of(space_t s, partition_t p, instance_t i);
    slot_t r;
    r = {s, p[1:0], (`FEAT_INSTANCE_CHOICE ? i[0] : 1'b0)};
    return r;
  endfunction

  // whether the selected partition and instance exist in this bank
  function automatic logic target_ok(partition_t p, instance_t i);
    logic ok;
    ok = (p < partition_t'(`PARTITION_COUNT));
    if (`FEAT_INSTANCE_CHOICE) begin
      ok = ok && (i < instance_t'(`INSTANCE_COUNT));
    end
    return ok;
  endfunction

  // root and realm frames only exist with the realm extension
  function automatic logic space_ok(space_t s);
    logic ok;
    ok = (s == SPACE_SECURE) || (s == SPACE_NONSECURE) || `FEAT_REALM_EXTENSION;
    return ok;
  endfunction

endpackage

`default_nettype wire

//--- rtl/cfg_lookup_if.sv
// read port from the configuration store to the bandwidth regulation side
`timescale 1ns/1ps
`default_nettype none

interface cfg_lookup_if;
  import bw_floor_pkg::*;
  slot_t slot;
  grant_idx_t word;
  fraction_t floor;
  grant_word_t grant;

  modport store (
    input slot,
    input word,
    output floor,
    output grant
  );

  modport user (
    output slot,
    output word,
    input floor,
    input grant
  );
endinterface

`default_nettype wire

//--- rtl/bw_floor_query.sv
// regulation-side lookup: floor preference and portion permission
`timescale 1ns/1ps
`default_nettype none
`include "bw_floor_consts.svh"

module bw_floor_query (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic qry_req_i,
  input wire bw_floor_pkg::space_t qry_space_i,
  input wire bw_floor_pkg::partition_t qry_partition_i,
  input wire bw_floor_pkg::instance_t qry_instance_i,
  input wire bw_floor_pkg::fraction_t qry_use_i,
  input wire bw_floor_pkg::portion_t qry_portion_i,
  cfg_lookup_if.user look,
  output logic qry_ack_o,
  output logic preferred_o,
  output logic portion_permit_o
);
  import bw_floor_pkg::*;

  // ========================================================================
  // lookup
  logic valid;

  assign valid = space_ok(qry_space_i) && target_ok(qry_partition_i, qry_instance_i)
                 && `FEAT_BW_PARTITIONING;
  assign look.slot = slot_of(qry_space_i, qry_partition_i, qry_instance_i);
  assign look.word = grant_idx_t'(qry_portion_i[`PORTION_WORD_MSB:`PORTION_WORD_LSB]);

  // ========================================================================
  // answers, registered one cycle after the request
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      qry_ack_o <= 1'b0;
    end else begin
      qry_ack_o <= qry_req_i;
    end
  end

  // both fraction values share the binary point above bit 15, so a plain
  // unsigned compare orders them
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      preferred_o <= 1'b0;
    end else if (qry_req_i) begin
      preferred_o <= valid && `FEAT_FLOOR_CONTROL && (qry_use_i < look.floor);
    end
  end

  // grant bits above portion 48 are never stored, so they always forbid
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      portion_permit_o <= 1'b0;
    end else if (qry_req_i) begin
      portion_permit_o <= valid && `FEAT_PORTION_MAP
                          && look.grant[qry_portion_i[`PORTION_BIT_MSB:0]];
    end
  end
endmodule // bw_floor_query

`default_nettype wire

//--- bench/bw_floor_monitor.sv
// port assertions of the floor and grant store
`timescale 1ns/1ps
`default_nettype none
`include "bw_floor_consts.svh"
module bw_floor_monitor (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic reg_req_i,
  input wire bw_floor_pkg::space_t reg_space_i,
  input wire logic [`FRAME_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_ack_o,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [`SPACE_COUNT-1:0] sel_internal_i,
  input wire logic qry_req_i,
  input wire logic qry_ack_o,
  input wire logic preferred_o,
  input wire logic portion_permit_o
);
  import bw_floor_pkg::*;
  logic rd;
  assign rd = reg_req_i && !reg_wr_i;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // ============
  // checks
  reg_ack_a: assert property (1'b1 |=> reg_ack_o == $past(reg_req_i))
    else $error("reg ack timing");
  qry_ack_a: assert property (1'b1 |=> qry_ack_o == $past(qry_req_i))
    else $error("query ack timing");
  write_zero_a: assert property (reg_req_i && reg_wr_i |=> reg_rdata_o == 32'h0)
    else $error("write data nonzero");
  floor_bits_a: assert property (rd && reg_addr_i == `OFS_FLOOR_FRACTION
    |=> reg_rdata_o[31:16] == 16'h0 && reg_rdata_o[3:0] == 4'h0) else $error("floor bits");
  grant_tail_a: assert property (rd && reg_addr_i == `OFS_GRANT_MAP_BASE + 14'h4
    |=> reg_rdata_o[31:17] == 15'h0) else $error("grant tail bits");
  flag_zero_a: assert property (rd && sel_internal_i[reg_space_i]
    |=> reg_rdata_o == 32'h0) else $error("flag read nonzero");
  rdata_hold_a: assert property (!reg_req_i |=> $stable(reg_rdata_o))
    else $error("read data moved");
  query_hold_a: assert property (!qry_req_i |=> $stable({preferred_o, portion_permit_o}))
    else $error("query result moved");
endmodule // bw_floor_monitor

bind bandwidth_floor_portion_config bw_floor_monitor mon (.core_clk_i, .srst_i, .reg_req_i,
  .reg_space_i, .reg_addr_i, .reg_wr_i, .reg_ack_o, .reg_rdata_o, .sel_internal_i,
  .qry_req_i, .qry_ack_o, .preferred_o, .portion_permit_o);
`default_nettype wire

//--- bench/bandwidth_floor_portion_config_tb.sv
// self-checking bench of the floor and grant store
`timescale 1ns/1ps
`default_nettype none
`include "bw_floor_consts.svh"
module bandwidth_floor_portion_config_tb;
  import bw_floor_pkg::*;
  localparam logic [31:0] FM = (32'hFFFF << (16 - `BW_FRACTION_WIDTH)) & 32'hFFFF;
  localparam logic [31:0] G1 = (32'h1 << (`PORTION_MAP_WIDTH - 31)) - 32'h1;
  localparam logic [13:0] FL = `OFS_FLOOR_FRACTION;
  localparam logic [13:0] GB = `OFS_GRANT_MAP_BASE;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic reg_req_i = 1'b0;
  logic reg_wr_i = 1'b0;
  space_t reg_space_i = SPACE_SECURE;
  logic [13:0] reg_addr_i = 14'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_ack_o;
  logic [31:0] reg_rdata_o;
  logic [3:0][7:0] selected_partition_field_i = 32'h0101_0101;
  logic [3:0][3:0] resource_instance_choice_i = 16'h0;
  logic [3:0] sel_internal_i = 4'h0;
  logic qry_req_i = 1'b0;
  space_t qry_space_i = SPACE_SECURE;
  partition_t qry_partition_i = 8'h0;
  instance_t qry_instance_i = 4'h0;
  fraction_t qry_use_i = 16'h0;
  portion_t qry_portion_i = 12'h0;
  logic qry_ack_o;
  logic preferred_o;
  logic portion_permit_o;
  int err_count = 0;
  int n_compared = 0;
  always #20 core_clk_i = ~core_clk_i;
  bandwidth_floor_portion_config uut (.core_clk_i, .srst_i, .reg_req_i, .reg_space_i,
    .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_ack_o, .reg_rdata_o, .selected_partition_field_i,
    .resource_instance_choice_i, .sel_internal_i, .qry_req_i, .qry_space_i, .qry_partition_i,
    .qry_instance_i, .qry_use_i, .qry_portion_i, .qry_ack_o, .preferred_o, .portion_permit_o);
  // ============
  // tasks
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t word %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t bit %b exp %b", $time, got, exp);
    end
  endtask
  // d is write data, or the expected word on a read; writes answer zero
  task automatic acc(input space_t s, input logic [13:0] a, input logic w, input logic [31:0] d);
    reg_req_i = 1'b1;
    reg_space_i = s;
    reg_addr_i = a;
    reg_wr_i = w;
    reg_wdata_i = d;
    @(negedge core_clk_i);
    cmp_bit(reg_ack_o, 1'b1);
    cmp_word(reg_rdata_o, w ? 32'h0 : d);
  endtask
  task automatic qry(input space_t s, input logic [7:0] p, input logic [3:0] i,
    input logic [15:0] u, input logic [11:0] n, input logic [1:0] e);
    qry_req_i = 1'b1;
    qry_space_i = s;
    qry_partition_i = p;
    qry_instance_i = i;
    qry_use_i = u;
    qry_portion_i = n;
    @(negedge core_clk_i);
    cmp_bit(qry_ack_o, 1'b1);
    cmp_bit(preferred_o, e[1]);
    cmp_bit(portion_permit_o, e[0]);
  endtask
  task automatic idle();
    reg_req_i = 1'b0;
    qry_req_i = 1'b0;
    @(negedge core_clk_i);
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ============
  // sequence; requests run back to back to stress the one-cycle answer
  initial begin
    repeat (6) @(negedge core_clk_i);
    srst_i = 1'b0;
    acc(SPACE_NONSECURE, FL, 1'b0, 32'h0);
    acc(SPACE_NONSECURE, FL, 1'b1, 32'hFFFF_FFFF);
    acc(SPACE_NONSECURE, FL, 1'b0, FM);
    for (int s = 0; s < 4; s++) begin
      acc(space_t'(s), FL, 1'b1, 32'hFFFF_0ABC + 32'h1000 * s);
    end
    for (int s = 0; s < 4; s++) begin
      acc(space_t'(s), FL, 1'b0, (32'h0ABC + 32'h1000 * s) & FM);
    end
    resource_instance_choice_i[1] = 4'h1;
    acc(SPACE_NONSECURE, FL, 1'b1, 32'h8000);
    resource_instance_choice_i[1] = 4'h0;
    sel_internal_i[1] = 1'b1;
    acc(SPACE_NONSECURE, FL, 1'b1, 32'h4440);
    acc(SPACE_NONSECURE, FL, 1'b0, 32'h0);
    sel_internal_i[1] = 1'b0;
    selected_partition_field_i[1] = 8'h04;
    acc(SPACE_NONSECURE, FL, 1'b1, 32'h5550);
    acc(SPACE_NONSECURE, FL, 1'b0, 32'h0);
    selected_partition_field_i[1] = 8'h01;
    resource_instance_choice_i[1] = 4'h2;
    acc(SPACE_NONSECURE, FL, 1'b1, 32'h6660);
    acc(SPACE_NONSECURE, FL, 1'b0, 32'h0);
    resource_instance_choice_i[1] = 4'h0;
    acc(SPACE_NONSECURE, FL, 1'b0, 32'h1ABC & FM);
    acc(SPACE_SECURE, 14'h0202, 1'b0, 32'h0);
    acc(SPACE_SECURE, 14'h0204, 1'b0, 32'h0);
    acc(SPACE_SECURE, GB, 1'b1, 32'h8000_0002);
    acc(SPACE_SECURE, GB + 14'h4, 1'b1, 32'hFFFF_FFFF);
    acc(SPACE_SECURE, GB + 14'h8, 1'b1, 32'hFFFF_FFFF);
    acc(SPACE_SECURE, GB + 14'h1, 1'b1, 32'hFFFF_FFFF);
    acc(SPACE_SECURE, GB + 14'h1, 1'b0, 32'h0);
    acc(SPACE_SECURE, GB, 1'b0, 32'h8000_0002);
    acc(SPACE_SECURE, GB + 14'h4, 1'b0, G1);
    acc(SPACE_SECURE, GB + 14'h8, 1'b0, 32'h0);
    acc(SPACE_REALM, GB + 14'h4, 1'b0, 32'h0);
    idle();
    qry(SPACE_SECURE, 8'h01, 4'h0, 16'h0AAF, 12'h001, 2'b11);
    qry(SPACE_SECURE, 8'h01, 4'h0, 16'h0AB0, 12'h000, 2'b00);
    qry(SPACE_SECURE, 8'h01, 4'h0, 16'h0000, 12'h01F, 2'b11);
    qry(SPACE_SECURE, 8'h01, 4'h0, 16'hFFFF, 12'h030, 2'b01);
    qry(SPACE_SECURE, 8'h01, 4'h0, 16'h0000, 12'h031, 2'b10);
    qry(SPACE_NONSECURE, 8'h01, 4'h1, 16'h7FFF, 12'h001, 2'b10);
    qry(SPACE_NONSECURE, 8'h00, 4'h0, 16'h0000, 12'h001, 2'b00);
    qry(SPACE_REALM, 8'h01, 4'h0, 16'h0000, 12'h021, 2'b10);
    qry(SPACE_NONSECURE, 8'h01, 4'h2, 16'h0000, 12'h001, 2'b00);
    qry(SPACE_SECURE, 8'h05, 4'h0, 16'h0000, 12'h001, 2'b00);
    idle();
    // a reset in mid-run must clear the secure frame's floor and grant word 0 of partition 1, the ones checked here
    srst_i = 1'b1;
    @(negedge core_clk_i);
    srst_i = 1'b0;
    acc(SPACE_SECURE, FL, 1'b0, 32'h0);
    acc(SPACE_SECURE, GB, 1'b0, 32'h0);
    qry(SPACE_SECURE, 8'h01, 4'h0, 16'h0000, 12'h001, 2'b00);
    idle();
    conclude();
  end
  // a hang ends the run as a failure
  initial begin
    repeat (3000) @(posedge core_clk_i);
    err_count++;
    conclude();
  end
endmodule // bandwidth_floor_portion_config_tb
`default_nettype wire
